// ### logic/dtc_channel.v
// One down-timer channel with its APB register set
// Functional notes
// [RQ1] Load value register at 0x0, 32 bits, read/write, resets to zero.
// [RQ2] Counter loads whatever value software last wrote to load register.
// [RQ3] Read-only present count at 0x4, resets zero; valid with bus clock.
// [RQ4] Software must not trust count readback under an independent counter clock.
// [RQ5] Control at 0x8: bit0 enable, bit1 mode, bit2 mask; rest zero.
// [RQ6] Mode 0 is free-running, mode 1 uses the user reload count.
// [RQ7] Mask 0 passes the interrupt, mask 1 suppresses the masked output.
// [RQ8] Interrupt sets when counter reaches terminal count.
// [RQ9] Read-only acknowledge at 0xc; any read clears the pending interrupt.
// [RQ10] Status at 0x10 bit 0 reports interrupt without clearing it.
// [RQ11] While enabled, counter decrements by one each clock edge.
// [RQ12] At zero reload from load value or all-ones, by mode.
// [RQ13] Disabled channel reads count zero and holds interrupt cleared.
// [RQ14] Combined interrupt output active when any unmasked interrupt is active.
// [RQ15] Unmasked latch keeps updating regardless of mask.
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_channel #(
  parameter WIDTH = 32
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire timer_irq_o,
  output wire timer_raw_irq_o,
  output wire combined_irq_o
);
  // ==========================================
  // Register file
  reg [WIDTH-1:0] reload_value;
  reg [`DTC_CTL_WIDTH-1:0] channel_control;
  wire [WIDTH-1:0] live_count;
  wire terminal;
  wire irq_raw;
  wire irq_masked;
  wire wr_access;
  wire rd_access;
  wire ack_read;
  reg [31:0] next_prdata;

  // APB 2.0: write and acknowledge read take effect in the enable phase; read data is registered in the setup phase
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign rd_access = psel_i & ~pwrite_i;
  assign ack_read = psel_i & penable_i & ~pwrite_i & (paddr_i == `DTC_OFS_INTERRUPT_ACK); // [RQ9]

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload_value <= `DTC_RST_RELOAD_VALUE; // [RQ1]
      channel_control <= `DTC_RST_CONTROL; // [RQ5]
    end else if (wr_access) begin
      case (paddr_i)
        `DTC_OFS_RELOAD_VALUE: reload_value <= pwdata_i[WIDTH-1:0]; // [RQ1] [RQ2]
        `DTC_OFS_CHANNEL_CONTROL: channel_control <= pwdata_i[`DTC_CTL_WIDTH-1:0]; // [RQ5]
        default: reload_value <= reload_value;
      endcase
    end
  end

  // ==========================================
  // Read mux; read data registered in the setup phase
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr_i)
      `DTC_OFS_RELOAD_VALUE: next_prdata = reload_value; // [RQ1]
      // Gate by enable so a read right after a disabling write still returns zero
      `DTC_OFS_LIVE_COUNT: next_prdata = channel_control[`DTC_CTL_EN_BIT] ?
        live_count : {WIDTH{1'b0}}; // [RQ3] [RQ13]
      `DTC_OFS_CHANNEL_CONTROL: next_prdata = {29'h0000000, channel_control}; // [RQ5]
      `DTC_OFS_INTERRUPT_ACK: next_prdata = 32'h00000000; // [RQ9]
      `DTC_OFS_INTERRUPT_FLAG: next_prdata = {31'h0, irq_masked}; // [RQ10]
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_access & ~penable_i) begin
      prdata_o <= next_prdata;
    end
  end

  // ==========================================
  // Counter and interrupt
  // Counter runs on the bus clock, so live_count readback is always exact
  dtc_counter #(
    .WIDTH(WIDTH)
  ) u_counter (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(channel_control[`DTC_CTL_EN_BIT]), // [RQ11]
    .user_mode_i(channel_control[`DTC_CTL_MODE_BIT]), // [RQ6]
    .reload_i(reload_value),
    .count_o(live_count),
    .terminal_o(terminal)
  );

  dtc_irq u_irq (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(channel_control[`DTC_CTL_EN_BIT]),
    .set_i(terminal),
    .clear_i(ack_read),
    .mask_i(channel_control[`DTC_CTL_MASK_BIT]), // [RQ7]
    .raw_o(irq_raw),
    .masked_o(irq_masked)
  );

  assign timer_raw_irq_o = irq_raw; // [RQ15]
  assign timer_irq_o = irq_masked;
  assign combined_irq_o = irq_masked; // [RQ14]
endmodule // dtc_channel

// ### logic/dtc_map.vh
// Register offsets, field positions and reset values of one down-timer channel
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// ==========================================
// Register offsets (byte addresses)
`define DTC_OFS_RELOAD_VALUE 8'h00
`define DTC_OFS_LIVE_COUNT 8'h04
`define DTC_OFS_CHANNEL_CONTROL 8'h08
`define DTC_OFS_INTERRUPT_ACK 8'h0c
`define DTC_OFS_INTERRUPT_FLAG 8'h10
// ==========================================
// Control fields
`define DTC_CTL_EN_BIT 0
`define DTC_CTL_MODE_BIT 1
`define DTC_CTL_MASK_BIT 2
`define DTC_CTL_WIDTH 3
// ==========================================
// Reset values
`define DTC_RST_RELOAD_VALUE 32'h00000000
`define DTC_RST_CONTROL 3'h0
`define DTC_COUNT_MAX 32'hffffffff
`endif

// ### logic/dtc_counter.v
// Down counter of one timer channel with reload and terminal-count pulse
`timescale 1ns/1ps
module dtc_counter #(
  parameter WIDTH = 32
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire enable_i,
  input wire user_mode_i,
  input wire [WIDTH-1:0] reload_i,
  output reg [WIDTH-1:0] count_o,
  output reg terminal_o
);
  reg enable_d;

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_o <= {WIDTH{1'b0}};
      enable_d <= 1'b0;
      terminal_o <= 1'b0;
    end else begin
      enable_d <= enable_i;
      terminal_o <= 1'b0;
      if (!enable_i) begin
        count_o <= {WIDTH{1'b0}}; // [RQ13]
      end else if (!enable_d) begin
        count_o <= reload_i; // [RQ2]
      end else if (count_o == {WIDTH{1'b0}}) begin
        // Wrap from zero is the terminal event
        count_o <= user_mode_i ? reload_i : {WIDTH{1'b1}}; // [RQ12] [RQ6]
        terminal_o <= 1'b1; // [RQ8]
      end else begin
        count_o <= count_o - {{(WIDTH-1){1'b0}}, 1'b1}; // [RQ11]
      end
    end
  end
endmodule // dtc_counter

// ### logic/dtc_irq.v
// Interrupt latch of one timer channel: set wins over clear, mask gates masked_o only
`timescale 1ns/1ps
module dtc_irq (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire enable_i,
  input wire set_i,
  input wire clear_i,
  input wire mask_i,
  output reg raw_o,
  output wire masked_o
);
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      raw_o <= 1'b0;
    end else if (!enable_i) begin
      raw_o <= 1'b0; // [RQ13]
    end else if (set_i) begin
      raw_o <= 1'b1; // [RQ8] [RQ15]
    end else if (clear_i) begin
      raw_o <= 1'b0; // [RQ9]
    end
  end

  assign masked_o = raw_o & ~mask_i; // [RQ7]
endmodule // dtc_irq

// ### bench/dtc_apb_host.sv
// APB host model driving the channel register port
`timescale 1ns/1ps
module dtc_apb_host (
  input wire clk_i,
  input wire [31:0] prdata_i,
  output reg psel_o,
  output reg penable_o,
  output reg pwrite_o,
  output reg [7:0] paddr_o,
  output reg [31:0] pwdata_o
);
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = 43'h0;
  // Count readback is used only because the counter runs on the bus clock
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    @(negedge clk_i) {psel_o, pwrite_o, paddr_o, pwdata_o} = {1'b1, w, a, d};
    @(negedge clk_i) penable_o = 1'b1;
    @(posedge clk_i) q = prdata_i;
    // Released address and data lines show inverted values so a stale address cannot pass
    @(negedge clk_i) {psel_o, penable_o, paddr_o, pwdata_o} = {2'h0, ~a, ~d};
  endtask
endmodule // dtc_apb_host

// ### bench/dtc_monitor.sv
// Port checker for one down-timer channel
`timescale 1ns/1ps
module dtc_monitor (
  input wire core_clk_i, input wire sys_rst_i, input wire psel_i, input wire penable_i,
  input wire pwrite_i, input wire [7:0] paddr_i, input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o, input wire timer_irq_o, input wire timer_raw_irq_o,
  input wire combined_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire rs = psel_i & ~penable_i & ~pwrite_i;
  wire ra = psel_i & penable_i & ~pwrite_i;
  wire off = psel_i & penable_i & pwrite_i & paddr_i == 8'h08 & ~pwdata_i[0];
  property p_cmb; combined_irq_o == timer_irq_o; endproperty
  a_cmb: assert property (p_cmb) else $error("bad combined irq");
  property p_msk; timer_irq_o |-> timer_raw_irq_o; endproperty
  a_msk: assert property (p_msk) else $error("irq without raw");
  property p_off; off |-> ##2 !timer_raw_irq_o; endproperty
  a_off: assert property (p_off) else $error("irq after disable");
  property p_sta; ra && paddr_i == 8'h10 && timer_raw_irq_o |=> timer_raw_irq_o; endproperty
  a_sta: assert property (p_sta) else $error("status read cleared");
  property p_stv; rs && paddr_i == 8'h10 |=> prdata_o == {31'h0, $past(timer_irq_o)}; endproperty
  a_stv: assert property (p_stv) else $error("bad status");
  property p_akv; rs && paddr_i == 8'h0c |=> prdata_o == 32'h0; endproperty
  a_akv: assert property (p_akv) else $error("bad ack data");
  property p_ctl; rs && paddr_i == 8'h08 |=> prdata_o[31:3] == 29'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("bad control bits");
  property p_unm; rs && paddr_i > 8'h10 |=> prdata_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("bad unmapped data");
endmodule // dtc_monitor
bind dtc_channel dtc_monitor i_mon (.*);

// ### bench/down_timer_channel_regs_test.sv
// Self-checking bench for one down-timer channel
`timescale 1ns/1ps
module down_timer_channel_regs_test;
  reg core_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  wire psel, pen, pwr, irq, raw, cmb;
  wire [7:0] pa;
  wire [31:0] pwd, prd;
  reg [31:0] q;
  integer n_errors = 0, compares = 0, cyc = 0, i;
  always #2 core_clk_i = ~core_clk_i;
  dtc_channel i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .timer_irq_o(irq), .timer_raw_irq_o(raw), .combined_irq_o(cmb));
  dtc_apb_host i_host (.clk_i(core_clk_i), .prdata_i(prd), .psel_o(psel),
    .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd));
  task ck(input string n, input [31:0] s, input [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    ck("prdata", q, e);
  endtask
  task t_regs;
    for (i = 0; i < 5; i++) rc(8'(i * 4), 32'h0);
    wr(8'h00, 32'ha5a5f00f);
    rc(8'h00, 32'ha5a5f00f);
    wr(8'h08, 32'hfffffff8);
    rc(8'h08, 32'h0);
    rc(8'h14, 32'h0);
  endtask
  task t_user;
    wr(8'h00, 32'h5);
    wr(8'h08, 32'h3);
    rc(8'h04, 32'h5);
    rc(8'h04, 32'h2);
    rc(8'h04, 32'h5);
    ck("irq", {raw, irq, cmb}, 32'h7);
    wr(8'h08, 32'h7);
    ck("irq", {raw, irq, cmb}, 32'h4);
    wr(8'h08, 32'h3);
    ck("irq", {raw, irq, cmb}, 32'h7);
    wr(8'h08, 32'h0);
    rc(8'h04, 32'h0);
    ck("irq", {raw, irq, cmb}, 32'h0);
  endtask
  task t_free;
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h1);
    rc(8'h04, 32'h2);
    rc(8'h04, 32'hffffffff);
    rc(8'h10, 32'h1);
    rc(8'h0c, 32'h0);
    ck("irq", {raw, irq, cmb}, 32'h0);
  endtask
  task t_reset;
    @(negedge core_clk_i) sys_rst_i = 1'b1;
    @(negedge core_clk_i) sys_rst_i = 1'b0;
    ck("irq", {raw, irq, cmb}, 32'h0);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Run is about 100 cycles, so a hang is cut at 1000
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i) sys_rst_i = 1'b0;
    t_regs;
    t_user;
    t_free;
    t_reset;
    report_and_stop;
  end
endmodule // down_timer_channel_regs_test
